/* File: hw/mtl_lookup.v */
// fixed-range memory type lookup with its model-register port
`timescale 1ns/1ps
`include "mtl_map.vh"
module mtl_lookup (
   // clock and reset
   input wire clock_in,
   input wire arst_n_in,
   // model-register port
   input wire msr_wr_in,
   input wire msr_rd_in,
   input wire [3:0] msr_index_in,
   input wire [63:0] msr_wdata_in,
   output reg msr_ack_out,
   output reg msr_fault_out,
   output wire [63:0] msr_rdata_out,
   // system controls
   input wire ext_types_enable_in,
   input wire cache_disable_control_in,
   // variable-range result from outside
   input wire var_hit_in,
   input wire [7:0] var_type_in,
   // lookup request
   input wire lookup_valid_in,
   input wire [51:0] lookup_addr_in,
   // resolved attributes
   output reg lookup_done_out,
   output reg [2:0] mem_type_out,
   output reg read_to_dram_flag_out,
   output reg write_to_dram_flag_out,
   output reg cacheable_out,
   output reg write_combine_ok_out,
   output reg speculative_ok_out,
   output reg alloc_read_miss_out,
   output reg alloc_write_miss_out,
   output reg write_through_out,
   output reg write_hit_invalidate_out,
   output reg alloc_modified_ok_out,
   output reg fixed_hit_out
);
   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // register index and field number from an address below 1 Mbyte
   function [6:0] fixed_select;
      input [19:0] a;
      begin
         if (a < `MTL_BASE_16K) begin
            fixed_select = {`MTL_IDX_FIX64K_00000, a[18:16]};
         end else if (a < `MTL_BASE_4K) begin
            fixed_select = {`MTL_IDX_FIX16K_80000 + {3'b000, a[17]}, a[16:14]};
         end else begin
            fixed_select = {`MTL_IDX_FIX4K_C0000 + {1'b0, a[17:15]}, a[14:12]};
         end
      end
   endfunction

   function is_fixed_index;
      input [3:0] idx;
      begin
         is_fixed_index = (idx <= `MTL_IDX_FIX4K_F8000);
      end
   endfunction

   // ----------------------------------------------------------------
   // default type register
   // ----------------------------------------------------------------
   reg [7:0] def_type_ff;
   reg def_fe_ff;
   reg def_e_ff;
   wire [63:0] def_word;
   wire msr_valid_idx;
   wire fix_wr;

   assign msr_valid_idx = is_fixed_index(msr_index_in) ||
                          (msr_index_in == `MTL_IDX_DEFAULT_TYPE);
   assign fix_wr = msr_wr_in && is_fixed_index(msr_index_in);
   assign def_word = {52'h0_0000_0000_0000, def_e_ff, def_fe_ff, 2'b00, def_type_ff};

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         def_type_ff <= `MTL_DEFAULT_RESET;
         def_fe_ff <= 1'b0;
         def_e_ff <= 1'b0;
      end else if (msr_wr_in && (msr_index_in == `MTL_IDX_DEFAULT_TYPE)) begin
         def_type_ff <= msr_wdata_in[7:0];
         def_fe_ff <= msr_wdata_in[`MTL_DEF_FE_BIT];
         def_e_ff <= msr_wdata_in[`MTL_DEF_E_BIT];
      end
   end

   // ----------------------------------------------------------------
   // register read / write handshake
   // ----------------------------------------------------------------
   reg rd_def_ff;
   reg [63:0] def_snap_ff;
   wire [63:0] fix_rdata;

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         msr_ack_out <= 1'b0;
         msr_fault_out <= 1'b0;
         rd_def_ff <= 1'b0;
         def_snap_ff <= 64'h0000_0000_0000_0000;
      end else begin
         msr_ack_out <= msr_wr_in || msr_rd_in;
         msr_fault_out <= (msr_wr_in || msr_rd_in) && !msr_valid_idx;
         if (msr_rd_in) begin
            rd_def_ff <= (msr_index_in == `MTL_IDX_DEFAULT_TYPE);
            def_snap_ff <= def_word;
         end
      end
   end

   assign msr_rdata_out = rd_def_ff ? def_snap_ff : fix_rdata;

   // ----------------------------------------------------------------
   // lookup stage one: address decode and memory read
   // ----------------------------------------------------------------
   reg s1_valid_ff;
   reg s1_below_1m_ff;
   reg s1_var_hit_ff;
   reg [7:0] s1_var_type_ff;
   wire below_1m;
   wire [6:0] sel;
   wire [7:0] fix_field;

   assign below_1m = (lookup_addr_in[`MTL_BELOW_1M_MSB:`MTL_BELOW_1M_LSB] == 32'h0000_0000);
   assign sel = fixed_select(lookup_addr_in[19:0]);

   mtl_fix_mem #(
      .NUM_REGS(`MTL_NUM_FIXED),
      .IDX_W(`MTL_IDX_W)
   ) u_fix_mem (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .wr_en_in(fix_wr),
      .wr_idx_in(msr_index_in),
      .wr_data_in(msr_wdata_in),
      .rd_en_in(msr_rd_in),
      .rd_idx_in(msr_index_in),
      .rd_data_out(fix_rdata),
      .lk_en_in(lookup_valid_in),
      .lk_idx_in(sel[6:3]),
      .lk_byte_in(sel[2:0]),
      .lk_field_out(fix_field)
   );

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s1_valid_ff <= 1'b0;
         s1_below_1m_ff <= 1'b0;
         s1_var_hit_ff <= 1'b0;
         s1_var_type_ff <= 8'h00;
      end else begin
         s1_valid_ff <= lookup_valid_in;
         if (lookup_valid_in) begin
            s1_below_1m_ff <= below_1m;
            s1_var_hit_ff <= var_hit_in;
            s1_var_type_ff <= var_type_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // lookup stage two: resolve the type
   // ----------------------------------------------------------------
   reg [2:0] nxt_type;
   reg nxt_rd_dram;
   reg nxt_wr_dram;
   reg nxt_fixed_hit;
   wire ext_on;

   assign ext_on = ext_types_enable_in && s1_below_1m_ff;

   always @* begin
      nxt_fixed_hit = 1'b0;
      // extended flags are independent of the global enable
      nxt_rd_dram = ext_on && fix_field[`MTL_RD_DRAM_BIT];
      nxt_wr_dram = ext_on && fix_field[`MTL_WR_DRAM_BIT];
      if (!def_e_ff) begin
         nxt_type = `MTL_UNCACHEABLE_TYPE;
      end else if (def_fe_ff && s1_below_1m_ff) begin
         nxt_type = fix_field[`MTL_TYPE_MSB:`MTL_TYPE_LSB];
         nxt_fixed_hit = 1'b1;
      end else if (s1_var_hit_ff) begin
         nxt_type = s1_var_type_ff[`MTL_TYPE_MSB:`MTL_TYPE_LSB];
      end else begin
         nxt_type = def_type_ff[`MTL_TYPE_MSB:`MTL_TYPE_LSB];
      end
   end

   // ----------------------------------------------------------------
   // policy decode per memory type
   // ----------------------------------------------------------------
   reg p_cache;
   reg p_wc;
   reg p_spec;
   reg p_arm;
   reg p_awm;
   reg p_wt;
   reg p_whi;
   reg p_mod;

   always @* begin
      p_cache = 1'b0;
      p_wc = 1'b0;
      p_spec = 1'b0;
      p_arm = 1'b0;
      p_awm = 1'b0;
      p_wt = 1'b0;
      p_whi = 1'b0;
      p_mod = 1'b0;
      case (nxt_type)
         `MTL_UNCACHEABLE_TYPE: begin
            p_cache = 1'b0;
         end
         `MTL_WRITE_COMBINING_TYPE: begin
            p_wc = 1'b1;
            p_spec = 1'b1;
         end
         `MTL_WRITETHROUGH_TYPE: begin
            p_cache = 1'b1;
            p_arm = 1'b1;
            p_wt = 1'b1;
         end
         `MTL_WRITE_PROTECT_TYPE: begin
            p_cache = 1'b1;
            p_arm = 1'b1;
            p_wt = 1'b1;
            p_whi = 1'b1;
         end
         `MTL_WRITEBACK_TYPE: begin
            p_cache = 1'b1;
            p_arm = 1'b1;
            p_awm = 1'b1;
            p_mod = 1'b1;
         end
         default: begin
            // undefined codes behave as uncacheable
            p_cache = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lookup_done_out <= 1'b0;
         mem_type_out <= `MTL_UNCACHEABLE_TYPE;
         read_to_dram_flag_out <= 1'b0;
         write_to_dram_flag_out <= 1'b0;
         cacheable_out <= 1'b0;
         write_combine_ok_out <= 1'b0;
         speculative_ok_out <= 1'b0;
         alloc_read_miss_out <= 1'b0;
         alloc_write_miss_out <= 1'b0;
         write_through_out <= 1'b0;
         write_hit_invalidate_out <= 1'b0;
         alloc_modified_ok_out <= 1'b0;
         fixed_hit_out <= 1'b0;
      end else begin
         lookup_done_out <= s1_valid_ff;
         if (s1_valid_ff) begin
            mem_type_out <= nxt_type;
            read_to_dram_flag_out <= nxt_rd_dram;
            write_to_dram_flag_out <= nxt_wr_dram;
            // cache disable only removes caching, never adds it
            cacheable_out <= p_cache && !cache_disable_control_in;
            write_combine_ok_out <= p_wc;
            speculative_ok_out <= p_spec;
            alloc_read_miss_out <= p_arm && !cache_disable_control_in;
            alloc_write_miss_out <= p_awm && !cache_disable_control_in;
            write_through_out <= p_wt;
            write_hit_invalidate_out <= p_whi;
            alloc_modified_ok_out <= p_mod;
            fixed_hit_out <= nxt_fixed_hit;
         end
      end
   end
endmodule

/* File: hw/mtl_map.vh */
// constants for the fixed-range memory type lookup
`ifndef MTL_MAP_VH
`define MTL_MAP_VH

// ----------------------------------------------------------------
// register indices on the model-register port
// ----------------------------------------------------------------
`define MTL_IDX_W 4
`define MTL_IDX_FIX64K_00000 4'h0
`define MTL_IDX_FIX16K_80000 4'h1
`define MTL_IDX_FIX16K_A0000 4'h2
`define MTL_IDX_FIX4K_C0000 4'h3
`define MTL_IDX_FIX4K_F8000 4'hA
`define MTL_IDX_DEFAULT_TYPE 4'hB
`define MTL_NUM_FIXED 11

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define MTL_REG_W 64
`define MTL_FIELD_W 8
`define MTL_TYPE_MSB 2
`define MTL_TYPE_LSB 0
`define MTL_RD_DRAM_BIT 4
`define MTL_WR_DRAM_BIT 3
`define MTL_DEF_FE_BIT 10
`define MTL_DEF_E_BIT 11
`define MTL_FIXED_RESET 64'h0000_0000_0000_0000
`define MTL_DEFAULT_RESET 8'h00

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define MTL_PADDR_W 52
`define MTL_BELOW_1M_MSB 51
`define MTL_BELOW_1M_LSB 20
`define MTL_BASE_16K 20'h8_0000
`define MTL_BASE_4K 20'hC_0000

// ----------------------------------------------------------------
// memory type codes
// ----------------------------------------------------------------
`define MTL_UNCACHEABLE_TYPE 3'h0
`define MTL_WRITE_COMBINING_TYPE 3'h1
`define MTL_WRITETHROUGH_TYPE 3'h4
`define MTL_WRITE_PROTECT_TYPE 3'h5
`define MTL_WRITEBACK_TYPE 3'h6

`endif

/* File: hw/mtl_fix_mem.v */
// storage for the fixed-range type registers with registered reads
`timescale 1ns/1ps
module mtl_fix_mem #(
   parameter NUM_REGS = 11,
   parameter IDX_W = 4
) (
   // clock and reset
   input wire clock_in,
   input wire arst_n_in,
   // write port
   input wire wr_en_in,
   input wire [IDX_W-1:0] wr_idx_in,
   input wire [63:0] wr_data_in,
   // whole-register read port
   input wire rd_en_in,
   input wire [IDX_W-1:0] rd_idx_in,
   output reg [63:0] rd_data_out,
   // single-field lookup port
   input wire lk_en_in,
   input wire [IDX_W-1:0] lk_idx_in,
   input wire [2:0] lk_byte_in,
   output reg [7:0] lk_field_out
);
   reg [63:0] mem_ff [0:NUM_REGS-1];
   wire [63:0] lk_word;

   // ----------------------------------------------------------------
   // register array
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g = g + 1) begin : g_reg
         always @(posedge clock_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               mem_ff[g] <= `MTL_FIXED_RESET;
            end else if (wr_en_in && (wr_idx_in == g)) begin
               mem_ff[g] <= wr_data_in;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // registered reads
   // ----------------------------------------------------------------
   assign lk_word = (lk_idx_in < NUM_REGS) ? mem_ff[lk_idx_in] : 64'h0000_0000_0000_0000;

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_out <= 64'h0000_0000_0000_0000;
         lk_field_out <= 8'h00;
      end else begin
         if (rd_en_in) begin
            rd_data_out <= (rd_idx_in < NUM_REGS) ? mem_ff[rd_idx_in] : 64'h0000_0000_0000_0000;
         end
         if (lk_en_in) begin
            lk_field_out <= lk_word[{lk_byte_in, 3'b000} +: 8];
         end
      end
   end
endmodule

/* File: verif/mtl_lookup_sva.sv */
// assertion checker for the fixed-range memory type lookup
`timescale 1ns/1ps
`include "mtl_map.vh"
module mtl_lookup_sva (
   // clock and reset
   input wire clock_in,
   input wire arst_n_in,
   // model-register port
   input wire msr_wr_in,
   input wire msr_rd_in,
   input wire [3:0] msr_index_in,
   input wire msr_ack_out,
   input wire msr_fault_out,
   // lookup side
   input wire ext_types_enable_in,
   input wire cache_disable_control_in,
   input wire lookup_valid_in,
   input wire [51:0] lookup_addr_in,
   input wire lookup_done_out,
   input wire [2:0] mem_type_out,
   input wire read_to_dram_flag_out,
   input wire cacheable_out,
   input wire write_combine_ok_out,
   input wire speculative_ok_out,
   input wire alloc_read_miss_out,
   input wire alloc_write_miss_out,
   input wire write_through_out,
   input wire write_hit_invalidate_out,
   input wire alloc_modified_ok_out
);
   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_req;
      msr_wr_in || msr_rd_in;
   endsequence
   sequence s_answer;
      ##1 msr_ack_out;
   endsequence
   sequence s_resolved;
      ##2 lookup_done_out;
   endsequence
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_ack_next_cycle: assert property (s_req |-> s_answer)
      else $error("register access without ack");
   a_fault_on_unmapped: assert property (msr_ack_out |-> msr_fault_out == ($past(msr_index_in) > 4'hB))
      else $error("fault does not match index");
   a_done_two_cycles: assert property (lookup_valid_in |-> s_resolved)
      else $error("lookup not done after two cycles");
   a_done_has_cause: assert property (lookup_done_out |-> $past(lookup_valid_in, 2))
      else $error("done without request");
   a_uc_policy: assert property (lookup_done_out && mem_type_out == `MTL_UNCACHEABLE_TYPE |->
      !(cacheable_out || write_combine_ok_out || speculative_ok_out)) else $error("uncacheable policy");
   a_wc_policy: assert property (lookup_done_out && mem_type_out == `MTL_WRITE_COMBINING_TYPE |->
      !cacheable_out && write_combine_ok_out && speculative_ok_out) else $error("combining policy");
   a_wt_policy: assert property (lookup_done_out && mem_type_out == `MTL_WRITETHROUGH_TYPE |->
      write_through_out && !write_hit_invalidate_out && !alloc_write_miss_out) else $error("wt policy");
   a_wp_policy: assert property (lookup_done_out && mem_type_out == `MTL_WRITE_PROTECT_TYPE |->
      write_through_out && write_hit_invalidate_out && !alloc_write_miss_out) else $error("wp policy");
   a_wb_policy: assert property (lookup_done_out && mem_type_out == `MTL_WRITEBACK_TYPE |->
      !write_through_out && (alloc_write_miss_out || $past(cache_disable_control_in)))
      else $error("wb policy");
   a_ext_flag_cause: assert property (lookup_done_out && read_to_dram_flag_out |->
      $past(ext_types_enable_in) && $past(lookup_addr_in[51:20], 2) == 32'h0)
      else $error("read flag without extended fixed hit");
   a_wt_read_alloc: assert property (lookup_done_out && !$past(cache_disable_control_in) &&
      mem_type_out == `MTL_WRITETHROUGH_TYPE |-> alloc_read_miss_out && cacheable_out)
      else $error("wt read allocate");
   a_wb_modified_ok: assert property (lookup_done_out && mem_type_out == `MTL_WRITEBACK_TYPE |->
      alloc_modified_ok_out) else $error("wb modified state");
   a_cd_no_cache: assert property (lookup_done_out && $past(cache_disable_control_in) |->
      !cacheable_out && !alloc_read_miss_out && !alloc_write_miss_out)
      else $error("caching while caches disabled");
endmodule
bind mtl_lookup mtl_lookup_sva u_sva (.clock_in, .arst_n_in, .msr_wr_in, .msr_rd_in,
   .msr_index_in, .msr_ack_out, .msr_fault_out, .ext_types_enable_in, .cache_disable_control_in,
   .lookup_valid_in, .lookup_addr_in, .lookup_done_out, .mem_type_out, .read_to_dram_flag_out,
   .cacheable_out, .write_combine_ok_out, .speculative_ok_out, .alloc_read_miss_out,
   .alloc_write_miss_out,
   .write_through_out, .write_hit_invalidate_out, .alloc_modified_ok_out);

/* File: verif/mtl_cache_model.sv */
// cache-pipeline side: issues lookups and keeps the resolved answer
`timescale 1ns/1ps
module mtl_cache_model (
   // clock
   input wire clock_in,
   // lookup request
   output logic lookup_valid_out,
   output logic [51:0] lookup_addr_out,
   output logic var_hit_out,
   output logic [7:0] var_type_out,
   // resolved answer
   input wire lookup_done_in,
   input wire [2:0] mem_type_in,
   input wire rd_flag_in,
   input wire wr_flag_in,
   input wire cacheable_in,
   input wire fixed_hit_in
);
   logic [7:0] got;
   initial begin
      lookup_valid_out = 1'b0;
      lookup_addr_out = 52'h0;
      var_hit_out = 1'b0;
      var_type_out = 8'h00;
      got = 8'h00;
   end
   task automatic lookup(input logic [51:0] a, input logic vh, input logic [7:0] vt);
      @(posedge clock_in);
      #2;
      lookup_valid_out = 1'b1;
      lookup_addr_out = a;
      var_hit_out = vh;
      var_type_out = vt;
      @(posedge clock_in);
      #2;
      // released lines carry the inverse so stale values are never trusted
      lookup_valid_out = 1'b0;
      lookup_addr_out = ~a;
      var_hit_out = ~vh;
      var_type_out = ~vt;
      // done stands for the one cycle after the edge that follows the request edge
      @(posedge clock_in);
      #1;
      got = {lookup_done_in, mem_type_in, rd_flag_in, wr_flag_in, cacheable_in, fixed_hit_in};
   endtask
endmodule

/* File: verif/mtl_lookup_tb.sv */
// self-checking bench for the fixed-range memory type lookup
`timescale 1ns/1ps
module mtl_lookup_tb;
   typedef struct {logic [51:0] a; logic vh; logic [7:0] vt; logic [7:0] exp;} mtl_row_t;
   logic clock_in, arst_n_in, msr_wr_in, msr_rd_in, msr_ack_out, msr_fault_out;
   logic [3:0] msr_index_in;
   logic [63:0] msr_wdata_in, msr_rdata_out, rd;
   logic ext_types_enable_in, cache_disable_control_in, var_hit_in, lookup_valid_in;
   logic [7:0] var_type_in;
   logic [51:0] lookup_addr_in;
   logic lookup_done_out, read_to_dram_flag_out, write_to_dram_flag_out, cacheable_out;
   logic write_combine_ok_out, speculative_ok_out, alloc_read_miss_out, alloc_write_miss_out;
   logic write_through_out, write_hit_invalidate_out, alloc_modified_ok_out, fixed_hit_out, flt;
   logic [2:0] mem_type_out;
   logic [63:0] fv [11];
   logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
   int mismatches = 0;
   int total_checks = 0;
   // rows: address, variable hit, variable type, {done,type,rd,wr,cacheable,fixed hit}
   mtl_row_t rows [12] = '{
      '{52'h0_0000, 1'b0, 8'h00, 8'h81}, '{52'h7_FFFF, 1'b0, 8'h00, 8'hC3},
      '{52'h8_0000, 1'b0, 8'h00, 8'h91}, '{52'h9_C000, 1'b0, 8'h00, 8'hD3},
      '{52'hA_4000, 1'b0, 8'h00, 8'hD3}, '{52'hC_0000, 1'b0, 8'h00, 8'hD3},
      '{52'hE_9000, 1'b0, 8'h00, 8'hE3}, '{52'hF_FFFF, 1'b0, 8'h00, 8'hC3},
      '{52'h10_0000, 1'b1, 8'h01, 8'h90}, '{52'h10_0000, 1'b0, 8'h00, 8'hE2},
      '{52'h10_0000, 1'b1, 8'h1C, 8'hC2}, '{52'h1_000F_FFFF, 1'b0, 8'h00, 8'hE2}};
   mtl_lookup dut (.clock_in, .arst_n_in, .msr_wr_in, .msr_rd_in, .msr_index_in, .msr_wdata_in,
      .msr_ack_out, .msr_fault_out, .msr_rdata_out, .ext_types_enable_in,
      .cache_disable_control_in, .var_hit_in, .var_type_in, .lookup_valid_in, .lookup_addr_in,
      .lookup_done_out, .mem_type_out, .read_to_dram_flag_out, .write_to_dram_flag_out,
      .cacheable_out, .write_combine_ok_out, .speculative_ok_out, .alloc_read_miss_out,
      .alloc_write_miss_out, .write_through_out, .write_hit_invalidate_out,
      .alloc_modified_ok_out, .fixed_hit_out);
   mtl_cache_model cm (.clock_in, .lookup_valid_out(lookup_valid_in),
      .lookup_addr_out(lookup_addr_in), .var_hit_out(var_hit_in), .var_type_out(var_type_in),
      .lookup_done_in(lookup_done_out), .mem_type_in(mem_type_out),
      .rd_flag_in(read_to_dram_flag_out), .wr_flag_in(write_to_dram_flag_out),
      .cacheable_in(cacheable_out), .fixed_hit_in(fixed_hit_out));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic model_specific_register(input logic wr, input logic [3:0] idx, input logic [63:0] d);
      @(posedge clock_in);
      #2;
      msr_wr_in = wr;
      msr_rd_in = !wr;
      msr_index_in = idx;
      msr_wdata_in = d;
      @(posedge clock_in);
      #2;
      msr_wr_in = 1'b0;
      msr_rd_in = 1'b0;
      // ack and fault stand only until the next edge
      chk({63'h0, msr_ack_out}, 64'h1, "ack");
      rd = msr_rdata_out;
      flt = msr_fault_out;
   endtask
   task automatic look(input logic [51:0] a, input logic vh, input logic [7:0] vt,
      input logic [7:0] exp);
      cm.lookup(a, vh, vt);
      chk({56'h0, cm.got}, {56'h0, exp}, "lookup");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------------------------------
   initial begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end
   initial begin
      #(25 * 4000);
      mismatches++;
      final_report();
   end
   initial begin
      {arst_n_in, msr_wr_in, msr_rd_in, ext_types_enable_in, cache_disable_control_in} = 5'b0;
      msr_index_in = 4'h0;
      msr_wdata_in = 64'h0;
      repeat (3) @(posedge clock_in);
      #2;
      arst_n_in = 1'b1;
      chk({61'h0, mem_type_out}, 64'h0, "reset type");
      model_specific_register(1'b0, 4'hB, 64'h0);
      chk(rd, 64'h0, "default reset");
      look(52'hF_FFFF, 1'b1, 8'h06, 8'h80);
      $display("test reset done");
      for (int i = 0; i < 11; i++) begin
         for (int n = 0; n < 8; n++) fv[i][8*n +: 8] = codes[(i + n) % 5];
         model_specific_register(1'b1, i[3:0], fv[i]);
      end
      for (int i = 0; i < 11; i++) begin
         model_specific_register(1'b0, i[3:0], 64'h0);
         chk(rd, fv[i], "readback");
         chk({63'h0, flt}, 64'h0, "mapped fault");
      end
      model_specific_register(1'b1, 4'hB, 64'hFFFF_FFFF_FFFF_FC06);
      model_specific_register(1'b0, 4'hB, 64'h0);
      chk(rd, 64'h0000_0000_0000_0C06, "default reg");
      foreach (rows[r]) look(rows[r].a, rows[r].vh, rows[r].vt, rows[r].exp);
      $display("test table done");
      model_specific_register(1'b1, 4'hB, 64'h0000_0000_0000_0806);
      look(52'h0, 1'b0, 8'h00, 8'hE2);
      model_specific_register(1'b1, 4'hB, 64'h0000_0000_0000_0406);
      look(52'hF_FFFF, 1'b1, 8'h06, 8'h80);
      $display("test enables done");
      model_specific_register(1'b1, 4'hB, 64'h0000_0000_0000_0C06);
      model_specific_register(1'b1, 4'h0, {fv[0][63:8], 8'h1E});
      look(52'h0, 1'b0, 8'h00, 8'hE3);
      ext_types_enable_in = 1'b1;
      look(52'h0, 1'b0, 8'h00, 8'hEF);
      look(52'h10_0000, 1'b1, 8'h1E, 8'hE2);
      model_specific_register(1'b1, 4'h0, {fv[0][63:8], 8'h14});
      look(52'h0, 1'b0, 8'h00, 8'hCB);
      $display("test extended done");
      cache_disable_control_in = 1'b1;
      look(52'h10_0000, 1'b0, 8'h00, 8'hE0);
      cache_disable_control_in = 1'b0;
      $display("test cache disable done");
      model_specific_register(1'b1, 4'h5, 64'hFEDC_BA98_7654_3210);
      model_specific_register(1'b0, 4'h5, 64'h0);
      chk(rd, 64'hFEDC_BA98_7654_3210, "full word");
      model_specific_register(1'b1, 4'hC, 64'hFFFF_FFFF_FFFF_FFFF);
      chk({63'h0, flt}, 64'h1, "unmapped write");
      model_specific_register(1'b0, 4'hC, 64'h0);
      chk({rd[62:0], flt}, 64'h1, "unmapped read");
      $display("test registers done");
      arst_n_in = 1'b0;
      repeat (3) @(posedge clock_in);
      #2;
      arst_n_in = 1'b1;
      model_specific_register(1'b0, 4'h5, 64'h0);
      chk(rd, 64'h0, "field after reset");
      look(52'h0, 1'b0, 8'h00, 8'h80);
      $display("test mid reset done");
      final_report();
   end
endmodule
